//--- logic/uda_pkg.sv
package uda_pkg;
    // ==========================================
    // register map (byte addresses on the host port)
    localparam logic [15:0] DEV1_ADDR_OFS = 16'hC08E;
    localparam logic [15:0] DEV1_FLAG_OFS = 16'hC090;
    localparam logic [15:0] DEV1_IEN_OFS = 16'hC08C;
    localparam logic [15:0] DEV2_ADDR_OFS = 16'hC0AE;
    localparam logic [15:0] DEV2_FLAG_OFS = 16'hC0B0;
    localparam logic [15:0] DEV2_IEN_OFS = 16'hC0AC;
    // ==========================================
    // field layout
    localparam int ADDR_W = 7;
    localparam int NUM_EP = 8;
    localparam int VBUS_BIT = 15;
    localparam int ID_BIT = 14;
    localparam int SOF_BIT = 9;
    localparam int RST_BIT = 8;
    localparam logic [15:0] DEV1_FLAG_MASK = 16'hC3FF;
    localparam logic [15:0] DEV2_FLAG_MASK = 16'h03FF;
    localparam logic [15:0] DEV1_IEN_MASK = 16'hC3FF;
    localparam logic [15:0] DEV2_IEN_MASK = 16'h03FF;
    // ==========================================
    // reset values
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [15:0] FLAG_RST = 16'h0000;
    localparam logic [15:0] IEN_RST = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ==========================================
    // endpoint completion codes
    typedef enum logic [2:0] {
        UDA_DONE_NONE,
        UDA_DONE_ACK,
        UDA_DONE_STALL,
        UDA_DONE_TIMEOUT,
        UDA_DONE_IN_ERR,
        UDA_DONE_OUT_ERR,
        UDA_DONE_NAK
    } uda_done_e;
endpackage

//--- logic/uda_top.sv
`timescale 1ns/10ps
// Operation
// - address register resets to zero, the default usb address.
// - only packets to the held address get a response; others ignored.
// - address sits in bits six to zero; upper bits reserved, read zero.
// - writing one clears a pending flag; writing zero leaves it.
// - status register readable and writable over the host port interface.
// - bus-voltage flag sets on both crossings of 4.4 V, first port only.
// - id flag sets on both edges of the id pin, first port only.
// - voltage and id flags exist only in the first instance.
// - sof/eop flag sets when start of frame or end of packet arrives.
// - reset flag sets on a detected usb bus reset.
// - endpoint flag sets on ack, stall, timeout, in or out error.
// - with nak enable set, a nak also sets the endpoint flag.
// - status registers at C090 and C0B0.
// - address registers at C08E and C0AE.
// - interrupt enable register bit-matches the flags and gates interrupts.
module uda_top #(
    parameter int NUM_EP = uda_pkg::NUM_EP
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic clk_en_i,
    // host port interface, 16-bit word access
    input wire logic [15:0] hpi_addr_i,
    input wire logic hpi_wr_i,
    input wire logic hpi_rd_i,
    input wire logic [15:0] hpi_wdata_i,
    output logic [15:0] hpi_rdata_o,
    output logic hpi_rvalid_o,
    // first port otg levels
    input wire logic vbus_above_i,
    input wire logic otg_id_i,
    // engine events, one per instance
    input wire logic [1:0] sof_eop_i,
    input wire logic [1:0] bus_reset_i,
    input wire logic [1:0] tok_valid_i,
    input wire logic [13:0] tok_addr_i,
    input wire logic [1:0] ep_done_i,
    input wire logic [5:0] ep_num_i,
    input wire logic [5:0] ep_code_i,
    input wire logic [2*NUM_EP-1:0] nak_ien_i,
    // outputs
    output logic [1:0] tok_accept_o,
    output logic [13:0] dev_addr_o,
    output logic [1:0] irq_o
);
    // ==========================================
    // state
    logic [6:0] dev_addr [2];
    logic [15:0] flags [2];
    logic [15:0] ien [2];
    logic vbus_q;
    logic id_q;
    logic edge_seen;

    function automatic logic [15:0] wr1c(input logic [15:0] cur, input logic [15:0] set,
                                         input logic clr_en, input logic [15:0] data,
                                         input logic [15:0] mask);
        logic [15:0] clr;
        clr = clr_en ? data : uda_pkg::ZERO16;
        return ((cur & ~clr) | set) & mask;
    endfunction

    function automatic logic [15:0] ep_bit(input logic hit, input logic [2:0] num,
                                           input logic [2:0] code, input logic nak_en);
        logic [15:0] b;
        logic take;
        b = uda_pkg::ZERO16;
        take = (code == uda_pkg::UDA_DONE_ACK) || (code == uda_pkg::UDA_DONE_STALL) ||
               (code == uda_pkg::UDA_DONE_TIMEOUT) || (code == uda_pkg::UDA_DONE_IN_ERR) ||
               (code == uda_pkg::UDA_DONE_OUT_ERR);
        if (code == uda_pkg::UDA_DONE_NAK) begin
            take = nak_en;
        end
        if (hit && take && (int'(num) < NUM_EP)) begin
            b[num] = 1'b1;
        end
        return b;
    endfunction

    // ==========================================
    // otg edge detect, first instance only
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            vbus_q <= 1'b0;
            id_q <= 1'b0;
            edge_seen <= 1'b0;
        end else if (clk_en_i) begin
            vbus_q <= vbus_above_i;
            id_q <= otg_id_i;
            // first sample after reset only primes the history, no false edge
            edge_seen <= 1'b1;
        end
    end

    logic [15:0] set_v [2];
    logic wr_addr [2];
    logic wr_flag [2];
    logic wr_ien [2];

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            set_v[i] = ep_bit(ep_done_i[i], ep_num_i[3*i +: 3], ep_code_i[3*i +: 3],
                              nak_ien_i[NUM_EP*i + int'(ep_num_i[3*i +: 3]) % NUM_EP]);
            set_v[i][uda_pkg::SOF_BIT] = sof_eop_i[i];
            set_v[i][uda_pkg::RST_BIT] = bus_reset_i[i];
        end
        set_v[0][uda_pkg::VBUS_BIT] = edge_seen && (vbus_q != vbus_above_i);
        set_v[0][uda_pkg::ID_BIT] = edge_seen && (id_q != otg_id_i);
        wr_addr[0] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV1_ADDR_OFS);
        wr_addr[1] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV2_ADDR_OFS);
        wr_flag[0] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV1_FLAG_OFS);
        wr_flag[1] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV2_FLAG_OFS);
        wr_ien[0] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV1_IEN_OFS);
        wr_ien[1] = hpi_wr_i && (hpi_addr_i == uda_pkg::DEV2_IEN_OFS);
    end

    // ==========================================
    // registers
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dev_addr[0] <= uda_pkg::ADDR_RST;
            dev_addr[1] <= uda_pkg::ADDR_RST;
        end else if (clk_en_i) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_addr[i]) begin
                    dev_addr[i] <= hpi_wdata_i[uda_pkg::ADDR_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            flags[0] <= uda_pkg::FLAG_RST;
            flags[1] <= uda_pkg::FLAG_RST;
        end else if (clk_en_i) begin
            flags[0] <= wr1c(flags[0], set_v[0], wr_flag[0], hpi_wdata_i, uda_pkg::DEV1_FLAG_MASK);
            flags[1] <= wr1c(flags[1], set_v[1], wr_flag[1], hpi_wdata_i, uda_pkg::DEV2_FLAG_MASK);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ien[0] <= uda_pkg::IEN_RST;
            ien[1] <= uda_pkg::IEN_RST;
        end else if (clk_en_i) begin
            if (wr_ien[0]) begin
                ien[0] <= hpi_wdata_i & uda_pkg::DEV1_IEN_MASK;
            end
            if (wr_ien[1]) begin
                ien[1] <= hpi_wdata_i & uda_pkg::DEV2_IEN_MASK;
            end
        end
    end

    // ==========================================
    // read port; address registers are write-only and read as zero
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            hpi_rdata_o <= uda_pkg::ZERO16;
            hpi_rvalid_o <= 1'b0;
        end else if (clk_en_i) begin
            hpi_rvalid_o <= hpi_rd_i;
            if (!hpi_rd_i) begin
                hpi_rdata_o <= uda_pkg::ZERO16;
            end else if (hpi_addr_i == uda_pkg::DEV1_FLAG_OFS) begin
                hpi_rdata_o <= flags[0];
            end else if (hpi_addr_i == uda_pkg::DEV2_FLAG_OFS) begin
                hpi_rdata_o <= flags[1];
            end else if (hpi_addr_i == uda_pkg::DEV1_IEN_OFS) begin
                hpi_rdata_o <= ien[0];
            end else if (hpi_addr_i == uda_pkg::DEV2_IEN_OFS) begin
                hpi_rdata_o <= ien[1];
            end else begin
                hpi_rdata_o <= uda_pkg::ZERO16;
            end
        end
    end

    // ==========================================
    // address filter and interrupt outputs
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tok_accept_o <= 2'h0;
            dev_addr_o <= 14'h0000;
            irq_o <= 2'h0;
        end else if (clk_en_i) begin
            for (int i = 0; i < 2; i++) begin
                // one cycle late against the token; the engine must wait for it
                tok_accept_o[i] <= tok_valid_i[i] && (tok_addr_i[7*i +: 7] == dev_addr[i]);
                dev_addr_o[7*i +: 7] <= dev_addr[i];
                irq_o[i] <= |(flags[i] & ien[i]);
            end
        end
    end
endmodule

//--- bench/uda_host_model.sv
`timescale 1ns/10ps
// ====================
// bus side: host traffic and transaction outcomes
module uda_host_model (
    input wire logic clk_i,
    output logic [1:0] sof_eop_o,
    output logic [1:0] bus_reset_o,
    output logic [1:0] tok_valid_o,
    output logic [13:0] tok_addr_o,
    output logic [1:0] ep_done_o,
    output logic [5:0] ep_num_o,
    output logic [5:0] ep_code_o
);
    initial {sof_eop_o, bus_reset_o, tok_valid_o, ep_done_o, tok_addr_o, ep_num_o, ep_code_o} = 34'h0;
    // k: 0 sof/eop, 1 bus reset, 2 token to a, 3 endpoint a ends with code c
    task automatic pulse(input int k, input int i, input logic [6:0] a, input logic [2:0] c);
        @(posedge clk_i);
        sof_eop_o[i] <= (k == 0);
        bus_reset_o[i] <= (k == 1);
        tok_valid_o[i] <= (k == 2);
        ep_done_o[i] <= (k == 3);
        tok_addr_o[7*i+:7] <= a;
        ep_num_o[3*i+:3] <= a[2:0];
        ep_code_o[3*i+:3] <= c;
        @(posedge clk_i);
        {sof_eop_o, bus_reset_o, tok_valid_o, ep_done_o} <= 8'h00;
        // released lines must not keep a stale value
        tok_addr_o <= ~tok_addr_o;
        ep_num_o <= ~ep_num_o;
    endtask
endmodule

//--- bench/uda_chk.sv
`timescale 1ns/10ps
// ====================
// port checker
module uda_chk #(
    parameter int NUM_EP = 8
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic clk_en_i,
    input wire logic [15:0] hpi_addr_i,
    input wire logic hpi_wr_i,
    input wire logic hpi_rd_i,
    input wire logic [15:0] hpi_wdata_i,
    input wire logic [15:0] hpi_rdata_o,
    input wire logic hpi_rvalid_o,
    input wire logic [1:0] tok_valid_i,
    input wire logic [13:0] tok_addr_i,
    input wire logic [1:0] tok_accept_o,
    input wire logic [13:0] dev_addr_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire logic rd1 = clk_en_i && hpi_rd_i;
    wire logic wr1 = clk_en_i && hpi_wr_i;
    wire logic tk0 = clk_en_i && tok_valid_i[0];
    property p_rst; disable iff (1'b0) srst_i |=> dev_addr_o == 14'h0000; endproperty
    a_rst: assert property (p_rst) else $error("address not zero after reset");
    property p_hit; tk0 && tok_addr_i[6:0] == dev_addr_o[6:0] |=> tok_accept_o[0]; endproperty
    a_hit: assert property (p_hit) else $error("matching token not accepted");
    property p_miss; tk0 && tok_addr_i[6:0] != dev_addr_o[6:0] |=> !tok_accept_o[0]; endproperty
    a_miss: assert property (p_miss) else $error("foreign token accepted");
    // address register lands one edge after the write, its output copy one edge later
    property p_wa1; wr1 && hpi_addr_i == uda_pkg::DEV1_ADDR_OFS |-> ##2 dev_addr_o[6:0] == $past(hpi_wdata_i[6:0], 2); endproperty
    a_wa1: assert property (p_wa1) else $error("first address not stored");
    property p_wa2; wr1 && hpi_addr_i == uda_pkg::DEV2_ADDR_OFS |-> ##2 dev_addr_o[13:7] == $past(hpi_wdata_i[6:0], 2); endproperty
    a_wa2: assert property (p_wa2) else $error("second address not stored");
    property p_ans; rd1 |=> hpi_rvalid_o; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_wo; rd1 && hpi_addr_i == uda_pkg::DEV1_ADDR_OFS |=> hpi_rdata_o == 16'h0000; endproperty
    a_wo: assert property (p_wo) else $error("write-only address read back");
    property p_res2; rd1 && hpi_addr_i == uda_pkg::DEV2_FLAG_OFS |=> hpi_rdata_o[15:14] == 2'b00; endproperty
    a_res2: assert property (p_res2) else $error("second status upper bits set");
endmodule
bind uda_top uda_chk #(.NUM_EP(NUM_EP)) i_chk (.*);

//--- bench/tb_top.sv
`timescale 1ns/10ps
// ====================
// bench: register access, address filter, event flags
module tb_top;
    logic ref_clk_i = 1'b0, srst_i = 1'b1, clk_en_i = 1'b1, hpi_wr_i = 1'b0, hpi_rd_i = 1'b0;
    logic vbus_above_i = 1'b0, otg_id_i = 1'b0, hpi_rvalid_o;
    logic [15:0] hpi_addr_i = 16'h0000, hpi_wdata_i = 16'h0000, nak_ien_i = 16'h0000, hpi_rdata_o;
    logic [1:0] sof_eop_i, bus_reset_i, tok_valid_i, ep_done_i, tok_accept_o, irq_o;
    logic [13:0] tok_addr_i, dev_addr_o;
    logic [5:0] ep_num_i, ep_code_i;
    int miscompares = 0, n_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    uda_top i_dut (.*);
    uda_host_model i_host (.clk_i(ref_clk_i), .sof_eop_o(sof_eop_i), .bus_reset_o(bus_reset_i),
        .tok_valid_o(tok_valid_i), .tok_addr_o(tok_addr_i), .ep_done_o(ep_done_i), .ep_num_o(ep_num_i),
        .ep_code_o(ep_code_i));
    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        {hpi_addr_i, hpi_wdata_i, hpi_wr_i} <= {a, d, 1'b1};
        @(posedge ref_clk_i);
        hpi_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        {hpi_addr_i, hpi_rd_i} <= {a, 1'b1};
        @(posedge ref_clk_i);
        hpi_rd_i <= 1'b0;
        #1 chk("rvalid", 16'(hpi_rvalid_o), 16'h0001);
        chk("rdata", hpi_rdata_o, e);
    endtask
    task automatic tok(input int i, input logic [6:0] a, input logic [15:0] e);
        i_host.pulse(2, i, a, 3'h0);
        #1 chk("accept", 16'(tok_accept_o), e);
    endtask
    // reset values, then address filter with both instances
    task automatic t_addr();
        chk("addr", {2'b00, dev_addr_o}, 16'h0000);
        tok(0, 7'h00, 16'h0001);
        wr(uda_pkg::DEV1_ADDR_OFS, 16'h0055);
        @(posedge ref_clk_i);
        #1 chk("addr1", 16'(dev_addr_o[6:0]), 16'h0055);
        rd(uda_pkg::DEV1_ADDR_OFS, 16'h0000);
        tok(0, 7'h55, 16'h0001);
        tok(0, 7'h54, 16'h0000);
        wr(uda_pkg::DEV2_ADDR_OFS, 16'h007F);
        tok(1, 7'h7F, 16'h0002);
        tok(1, 7'h00, 16'h0000);
        rd(16'hC0A0, 16'h0000);
    endtask
    // every event source, clear by one, set wins over clear
    task automatic t_flags();
        rd(uda_pkg::DEV1_FLAG_OFS, 16'h0000);
        @(posedge ref_clk_i);
        {nak_ien_i[7], vbus_above_i, otg_id_i} <= 3'b111;
        i_host.pulse(0, 0, 7'h00, 3'h0);
        i_host.pulse(1, 0, 7'h00, 3'h0);
        i_host.pulse(3, 1, 7'h02, 3'h2);
        i_host.pulse(3, 0, 7'h07, 3'h6);
        i_host.pulse(3, 0, 7'h00, 3'h0);
        for (int c = 6; c > 0; c--) i_host.pulse(3, 0, 7'(c), 3'(c));
        rd(uda_pkg::DEV1_FLAG_OFS, 16'hC3BE);
        rd(uda_pkg::DEV2_FLAG_OFS, 16'h0004);
        fork
            i_host.pulse(0, 0, 7'h00, 3'h0);
            wr(uda_pkg::DEV1_FLAG_OFS, 16'hC3BE);
        join
        rd(uda_pkg::DEV1_FLAG_OFS, 16'h0200);
        wr(uda_pkg::DEV1_FLAG_OFS, 16'h0000);
        @(posedge ref_clk_i);
        vbus_above_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        rd(uda_pkg::DEV1_FLAG_OFS, 16'h8200);
    endtask
    // enable gates the interrupt; clearing the flag drops it
    task automatic t_irq();
        wr(uda_pkg::DEV1_IEN_OFS, 16'h0200);
        @(posedge ref_clk_i);
        #1 chk("irq", 16'(irq_o), 16'h0001);
        wr(uda_pkg::DEV1_FLAG_OFS, 16'h0200);
        @(posedge ref_clk_i);
        #1 chk("irq", 16'(irq_o), 16'h0000);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1 t_addr();
        t_flags();
        t_irq();
        close_out();
    end
endmodule
